// ---- ispc_pkg.sv ----
// Constants, register map and carrier types of the idle and stop power controller
package ispc_pkg;

   // Register bus
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam logic [7:0] OFS_SELECT = 8'h00;
   localparam logic [7:0] OFS_TRIGGER = 8'h04;
   localparam logic [7:0] OFS_SETTLE = 8'h08;
   localparam logic [7:0] OFS_PERIPH = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   // Field positions
   localparam int unsigned STOP_SELECT_POS = 0;
   localparam int unsigned TRIGGER_POS = 0;
   localparam int unsigned SETTLE_W = 3;
   localparam int unsigned RTC_BAUD_POS = 0;
   localparam int unsigned RTC_SUB_POS = 1;
   localparam int unsigned SUBCLK_USED_POS = 2;
   localparam int unsigned ADC_BAUD_POS = 3;
   localparam int unsigned CSI_EXT_LSB = 4;
   localparam int unsigned CSI_COUNT = 5;
   localparam int unsigned EXT_MASK_LSB = 12;
   localparam int unsigned EXT_PIN_COUNT = 7;
   localparam int unsigned PERIPH_W = 19;
   localparam int unsigned STAT_STATE_LSB = 0;
   localparam int unsigned STAT_DAC_HOLD_POS = 4;
   localparam int unsigned STAT_SETTLING_POS = 5;
   localparam int unsigned STAT_RESET_POS = 6;
   localparam int unsigned PRIO_W = 3;

   // Reset values: settle select 6 gives 2^19 main-clock periods with the default base
   localparam logic [SETTLE_W-1:0] SETTLE_RESET = 3'h6;
   localparam logic [PERIPH_W-1:0] PERIPH_RESET = 19'h7_f000;

   // Timing: the core clock is the main oscillator clock
   localparam int unsigned CLOCK_PERIOD_NS = 10;
   localparam int unsigned RESET_SETTLE_PERIODS = 524288;
   localparam int unsigned SETTLE_BASE_PERIODS = 8192;
   localparam int unsigned CNT_W = 21;

   typedef enum logic [1:0] {
      ST_NORMAL,
      ST_IDLE,
      ST_STOP,
      ST_SETTLE
   } ispc_state_e;

   typedef struct packed {
      logic main_osc;
      logic sub_osc;
      logic cpu;
      logic periph;
      logic rtc;
      logic adc;
      logic dac;
      logic [CSI_COUNT-1:0] csi;
   } ispc_clk_en_s;

   typedef struct packed {
      logic nmi;
      logic handler;
      logic next_instr;
      logic ack;
   } ispc_wake_s;

endpackage : ispc_pkg

// ---- ispc_ctrl.sv ----
// Idle and software stop power controller: mode entry, clock gating, wake-up and settle wait
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/10ps

module ispc_ctrl
   import ispc_pkg::*;
#(
   parameter int unsigned RESET_SETTLE_CYCLES = RESET_SETTLE_PERIODS,
   parameter int unsigned SETTLE_BASE_CYCLES = SETTLE_BASE_PERIODS
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] address,
   input wire logic [DATA_W-1:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [DATA_W-1:0] read_data,
   input wire logic reset_pin,
   input wire logic nmi_req,
   input wire logic [EXT_PIN_COUNT-1:0] ext_int_pins,
   input wire logic periph_int_req,
   input wire logic [PRIO_W-1:0] req_priority,
   input wire logic serv_active,
   input wire logic [PRIO_W-1:0] serv_priority,
   input wire logic ints_enabled_state,
   input wire logic dac_busy,
   output ispc_clk_en_s clk_en,
   output ispc_wake_s wake,
   output logic port_hold,
   output logic dac_hold,
   output logic cpu_reset
);

   ispc_state_e state;
   ispc_state_e next_state;
   logic stop_select_bit;
   logic [SETTLE_W-1:0] osc_settle_select;
   logic [PERIPH_W-1:0] periph_cfg;
   logic [CNT_W-1:0] settle_cnt;
   logic [CNT_W-1:0] next_settle_cnt;
   ispc_wake_s held_wake;
   ispc_wake_s next_held_wake;
   ispc_wake_s next_wake;
   ispc_clk_en_s next_clk_en;
   logic reset_seen;
   logic next_reset_seen;
   logic next_dac_hold;
   logic [DATA_W-1:0] next_read_data;

   // Address decode
   wire logic sel_select = (address == OFS_SELECT);
   wire logic sel_trigger = (address == OFS_TRIGGER);
   wire logic sel_settle = (address == OFS_SETTLE);
   wire logic sel_periph = (address == OFS_PERIPH);
   wire logic sel_status = (address == OFS_STATUS);
   // The CPU is clock-gated outside normal operation, so writes land only there
   wire logic write_ok = write_strobe && (state == ST_NORMAL) && !reset_pin;
   wire logic trigger_write = write_ok && sel_trigger && write_data[TRIGGER_POS];

   // Configuration fields
   wire logic rtc_baud = periph_cfg[RTC_BAUD_POS];
   wire logic rtc_sub = periph_cfg[RTC_SUB_POS];
   wire logic subclk_used = periph_cfg[SUBCLK_USED_POS];
   wire logic adc_baud = periph_cfg[ADC_BAUD_POS];
   wire logic [CSI_COUNT-1:0] csi_ext = periph_cfg[CSI_EXT_LSB +: CSI_COUNT];
   wire logic [EXT_PIN_COUNT-1:0] ext_mask = periph_cfg[EXT_MASK_LSB +: EXT_PIN_COUNT];

   // Wake sources and the resume decision
   wire logic ext_wake = |(ext_int_pins & ~ext_mask);
   wire logic maskable_wake = ext_wake || periph_int_req;
   wire logic wake_any = nmi_req || maskable_wake;
   // Lower code means higher priority; with nothing in service anything outranks it
   wire logic outranks = !serv_active || (req_priority < serv_priority);
   wire logic maskable_ack = ints_enabled_state && outranks;
   wire ispc_wake_s decision = nmi_req
      ? ispc_wake_s'{nmi: 1'b1, handler: 1'b1, next_instr: 1'b0, ack: 1'b1}
      : maskable_ack
      ? ispc_wake_s'{nmi: 1'b0, handler: 1'b1, next_instr: 1'b0, ack: 1'b1}
      : ispc_wake_s'{nmi: 1'b0, handler: 1'b0, next_instr: 1'b1, ack: 1'b0};

   // Settle load values; the programmed one shifts the base left by the selection, scaling it by 2^selection
   wire logic [CNT_W-1:0] settle_programmed =
      CNT_W'(SETTLE_BASE_CYCLES) << osc_settle_select;
   wire logic [CNT_W-1:0] settle_reset_load = CNT_W'(RESET_SETTLE_CYCLES);
   wire logic settle_done = (state == ST_SETTLE) && (settle_cnt <= CNT_W'(1));
   wire logic stop_side = (state == ST_STOP) || (state == ST_SETTLE);

   always_comb begin
      next_state = state;
      next_settle_cnt = settle_cnt;
      next_held_wake = held_wake;
      next_wake = '0;
      next_reset_seen = reset_seen;
      if (reset_pin) begin
         // Stop or its settle: oscillator must restart, so the reset-value wait applies
         if (stop_side) begin
            next_state = ST_SETTLE;
            next_settle_cnt = settle_reset_load;
         end else begin
            next_state = ST_NORMAL;
            next_settle_cnt = '0;
         end
         next_held_wake = '0;
         next_reset_seen = 1'b1;
      end else begin
         unique case (state)
            ST_NORMAL: begin
               next_reset_seen = 1'b0;
               if (trigger_write) begin
                  next_state = stop_select_bit ? ST_STOP : ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (wake_any) begin
                  next_state = ST_NORMAL;
                  next_wake = decision;
               end
            end
            ST_STOP: begin
               if (wake_any) begin
                  next_state = ST_SETTLE;
                  next_settle_cnt = settle_programmed;
                  next_held_wake = decision;
               end
            end
            ST_SETTLE: begin
               next_settle_cnt = settle_cnt - CNT_W'(1);
               if (settle_done) begin
                  next_state = ST_NORMAL;
                  next_wake = held_wake;
                  next_held_wake = '0;
                  next_settle_cnt = '0;
               end
            end
         endcase
      end
   end

   // Clock gating by the mode being entered
   always_comb begin
      next_clk_en = '0;
      next_clk_en.sub_osc = 1'b1;
      unique case (next_state)
         ST_NORMAL: begin
            next_clk_en = '1;
         end
         ST_IDLE: begin
            next_clk_en.main_osc = 1'b1;
            next_clk_en.rtc = rtc_baud || subclk_used;
            next_clk_en.csi = csi_ext;
            next_clk_en.adc = adc_baud;
            // A conversion under way keeps its clock until it completes
            next_clk_en.dac = dac_busy;
         end
         ST_STOP: begin
            next_clk_en.main_osc = 1'b0;
            next_clk_en.rtc = subclk_used && rtc_sub;
            next_clk_en.csi = csi_ext;
         end
         ST_SETTLE: begin
            next_clk_en.main_osc = 1'b1;
            next_clk_en.rtc = subclk_used && rtc_sub;
            next_clk_en.csi = csi_ext;
         end
      endcase
   end

   assign next_dac_hold = (next_state == ST_IDLE) && !dac_busy;

   // Read mux; unmapped addresses read zero
   wire logic [DATA_W-1:0] status_word = {
      {(DATA_W - STAT_RESET_POS - 1){1'b0}},
      reset_seen,
      (state == ST_SETTLE),
      dac_hold,
      2'b00,
      state
   };
   assign next_read_data = !read_strobe ? '0
      : sel_select ? DATA_W'(stop_select_bit)
      : sel_trigger ? DATA_W'(state != ST_NORMAL)
      : sel_settle ? DATA_W'(osc_settle_select)
      : sel_periph ? DATA_W'(periph_cfg)
      : sel_status ? status_word
      : '0;

   // Registers software writes
   always_ff @(posedge clock) begin
      if (reset || reset_pin) begin
         stop_select_bit <= 1'b0;
         osc_settle_select <= SETTLE_RESET;
         periph_cfg <= PERIPH_RESET;
      end else begin
         if (write_ok && sel_select) begin
            stop_select_bit <= write_data[STOP_SELECT_POS];
         end
         if (write_ok && sel_settle) begin
            osc_settle_select <= write_data[SETTLE_W-1:0];
         end
         if (write_ok && sel_periph) begin
            periph_cfg <= write_data[PERIPH_W-1:0];
         end
      end
   end

   // Mode state and outputs
   always_ff @(posedge clock) begin
      if (reset) begin
         state <= ST_NORMAL;
         settle_cnt <= '0;
         held_wake <= '0;
         wake <= '0;
         reset_seen <= 1'b0;
         clk_en <= '1;
         dac_hold <= 1'b0;
         port_hold <= 1'b0;
         cpu_reset <= 1'b0;
         read_data <= '0;
      end else begin
         state <= next_state;
         settle_cnt <= next_settle_cnt;
         held_wake <= next_held_wake;
         wake <= next_wake;
         reset_seen <= next_reset_seen;
         clk_en <= next_clk_en;
         dac_hold <= next_dac_hold;
         port_hold <= (next_state != ST_NORMAL);
         cpu_reset <= reset_pin || (next_reset_seen && next_state != ST_NORMAL);
         read_data <= next_read_data;
      end
   end

   // Checks
   a_stop_entry: assert property (@(posedge clock) disable iff (reset)
      (state == ST_NORMAL && trigger_write && stop_select_bit && !reset_pin)
      |=> (state == ST_STOP) ##0 !clk_en.main_osc ##0 !clk_en.cpu)
      else $error("stop not entered after trigger with stop select set");

   a_idle_entry: assert property (@(posedge clock) disable iff (reset)
      (state == ST_NORMAL && trigger_write && !stop_select_bit && !reset_pin)
      |=> (state == ST_IDLE) && clk_en.main_osc && !clk_en.cpu && !clk_en.periph)
      else $error("idle not entered with oscillator on and cpu gated");

   a_idle_exit: assert property (@(posedge clock) disable iff (reset)
      (state == ST_IDLE && wake_any && !reset_pin)
      |=> (state == ST_NORMAL) && clk_en.cpu && (wake != '0))
      else $error("idle exit did not resume at once");

   a_stop_osc_off: assert property (@(posedge clock) disable iff (reset)
      (state == ST_STOP) |-> !clk_en.main_osc && clk_en.sub_osc && !clk_en.adc)
      else $error("main oscillator running in stop");

   a_settle_length: assert property (@(posedge clock) disable iff (reset)
      (state == ST_STOP && wake_any && !reset_pin && osc_settle_select == 3'h0)
      |=> (state == ST_SETTLE) && (settle_cnt == CNT_W'(SETTLE_BASE_CYCLES)))
      else $error("settle wait loaded with wrong length");

   a_settle_hold: assert property (@(posedge clock) disable iff (reset)
      (state == ST_SETTLE && settle_cnt > CNT_W'(1) && !reset_pin)
      |=> (state == ST_SETTLE) && !clk_en.cpu && $past(settle_cnt) == settle_cnt + CNT_W'(1))
      else $error("settle wait ended early");

   a_reset_settle: assert property (@(posedge clock) disable iff (reset)
      (state == ST_STOP && reset_pin)
      |=> (state == ST_SETTLE) && (settle_cnt == settle_reset_load) && cpu_reset)
      else $error("reset-pin wake from stop did not use reset settle value");

   a_idle_reset: assert property (@(posedge clock) disable iff (reset)
      (state == ST_IDLE && reset_pin)
      |=> (state == ST_NORMAL) && cpu_reset && (osc_settle_select == SETTLE_RESET))
      else $error("reset pin in idle did not reset");

   a_nmi_branch: assert property (@(posedge clock) disable iff (reset)
      (state == ST_IDLE && nmi_req && !reset_pin)
      |=> wake.nmi && wake.handler && wake.ack && !wake.next_instr)
      else $error("nmi wake did not branch to handler");

   a_di_next: assert property (@(posedge clock) disable iff (reset)
      (state == ST_IDLE && !nmi_req && maskable_wake && !ints_enabled_state && !reset_pin)
      |=> wake.next_instr && !wake.ack && !wake.handler)
      else $error("disabled maskable wake did not resume at next instruction");

   a_low_prio: assert property (@(posedge clock) disable iff (reset)
      (state == ST_IDLE && !nmi_req && maskable_wake && serv_active
       && req_priority >= serv_priority && !reset_pin)
      |=> !wake.ack ##1 !wake.ack)
      else $error("lower priority request was acknowledged");

   a_port_hold: assert property (@(posedge clock) disable iff (reset)
      (state != ST_NORMAL) |-> port_hold)
      else $error("ports released during power save");

   a_idle_rtc: assert property (@(posedge clock) disable iff (reset)
      (state == ST_IDLE && $past(state) == ST_IDLE)
      |-> clk_en.rtc == $past(rtc_baud || subclk_used))
      else $error("real-time counter gating wrong in idle");

   a_dac_finish: assert property (@(posedge clock) disable iff (reset)
      (state == ST_IDLE && dac_busy && $past(state) == ST_IDLE && !reset_pin)
      |=> (state != ST_IDLE) || clk_en.dac || dac_hold)
      else $error("conversion cut short on idle entry");

   a_cfg_kept: assert property (@(posedge clock) disable iff (reset)
      (state != ST_NORMAL && !reset_pin)
      |=> $stable(stop_select_bit) && $stable(osc_settle_select) && $stable(periph_cfg))
      else $error("configuration changed during power save");

   a_stop_wake: assert property (@(posedge clock) disable iff (reset)
      (state == ST_STOP && wake_any && !reset_pin)
      |=> (state == ST_SETTLE) && clk_en.main_osc && !clk_en.cpu && (wake == '0))
      else $error("stop not left for settle on wake request");

   a_settle_exit: assert property (@(posedge clock) disable iff (reset)
      (state == ST_SETTLE && settle_cnt <= CNT_W'(1) && !reset_pin)
      |=> (state == ST_NORMAL) && (clk_en == '1) && !port_hold)
      else $error("settle end did not restore normal operation");

   a_idle_periph: assert property (@(posedge clock) disable iff (reset)
      (state == ST_IDLE)
      |-> (clk_en.csi == csi_ext) && (clk_en.adc == adc_baud) && !clk_en.periph)
      else $error("serial or converter gating wrong in idle");

endmodule : ispc_ctrl

// ---- ispc_req_model.sv ----
// Model of the NMI, external-pin and peripheral interrupt sources that raise wake-up requests
`timescale 1ns/10ps
module ispc_req_model
   import ispc_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic fire,
   input wire logic [1:0] source,
   input wire logic [2:0] pin,
   input wire ispc_wake_s wake,
   output logic nmi_req,
   output logic [EXT_PIN_COUNT-1:0] ext_int_pins,
   output logic periph_int_req
);
   // Lines are levels held until any wake pulse, acknowledged or not, which clears every line
   always_ff @(posedge clock) begin
      if (reset || wake != 4'h0) begin
         nmi_req <= 1'h0;
         ext_int_pins <= 7'h00;
         periph_int_req <= 1'h0;
      end else if (fire) begin
         nmi_req <= (source == 2'h0);
         ext_int_pins <= (source == 2'h1) ? (7'h01 << pin) : 7'h00;
         periph_int_req <= (source == 2'h2);
      end
   end
endmodule : ispc_req_model

// ---- ispc_ctrl_bench.sv ----
// Self-checking bench of the idle and stop power controller
`timescale 1ns/10ps
module ispc_ctrl_bench
   import ispc_pkg::*;
;
   localparam int RST_CYC = 40;
   localparam int BASE = 4;
   logic clock = 1'h0;
   logic reset = 1'h1;
   logic [ADDR_W-1:0] address = 8'h00;
   logic [DATA_W-1:0] write_data = 32'h0000_0000;
   logic write_strobe = 1'h0;
   logic read_strobe = 1'h0;
   logic [DATA_W-1:0] read_data;
   logic reset_pin = 1'h0;
   logic nmi_req;
   logic [EXT_PIN_COUNT-1:0] ext_int_pins;
   logic periph_int_req;
   logic [PRIO_W-1:0] req_priority = 3'h0;
   logic serv_active = 1'h0;
   logic [PRIO_W-1:0] serv_priority = 3'h0;
   logic ints_enabled_state = 1'h0;
   logic dac_busy = 1'h0;
   ispc_clk_en_s clk_en;
   ispc_wake_s wake;
   logic port_hold;
   logic dac_hold;
   logic cpu_reset;
   logic fire = 1'h0;
   logic [1:0] source = 2'h0;
   logic [2:0] pin = 3'h0;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;

   always #5 clock = ~clock;

   ispc_ctrl #(.RESET_SETTLE_CYCLES(RST_CYC), .SETTLE_BASE_CYCLES(BASE)) ispc_ctrl_inst (
      .clock(clock), .reset(reset), .address(address), .write_data(write_data),
      .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
      .reset_pin(reset_pin), .nmi_req(nmi_req), .ext_int_pins(ext_int_pins),
      .periph_int_req(periph_int_req), .req_priority(req_priority),
      .serv_active(serv_active), .serv_priority(serv_priority),
      .ints_enabled_state(ints_enabled_state), .dac_busy(dac_busy), .clk_en(clk_en),
      .wake(wake), .port_hold(port_hold), .dac_hold(dac_hold), .cpu_reset(cpu_reset));

   ispc_req_model ispc_req_model_inst (
      .clock(clock), .reset(reset), .fire(fire), .source(source), .pin(pin),
      .wake(wake), .nmi_req(nmi_req), .ext_int_pins(ext_int_pins),
      .periph_int_req(periph_int_req));

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      address <= a;
      write_data <= d;
      write_strobe <= 1'h1;
      @(posedge clock);
      write_strobe <= 1'h0;
      #1;
   endtask : wr

   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      address <= a;
      read_strobe <= 1'h1;
      @(posedge clock);
      read_strobe <= 1'h0;
      #1;
      chk(what, exp, read_data);
   endtask : rd

   // Enters idle or stop, then keeps the request quiet for the five no-operation slots
   task automatic enter(input logic stop);
      wr(OFS_SELECT, {31'h0000_0000, stop});
      wr(OFS_TRIGGER, 32'h0000_0001);
      chk("cpu clock off", 1'h0, clk_en.cpu);
      chk("periph clock off", 1'h0, clk_en.periph);
      chk("main osc", {31'h0000_0000, !stop}, clk_en.main_osc);
      chk("port hold", 1'h1, port_hold);
      repeat (5) @(posedge clock);
   endtask : enter

   // Raises one request and counts edges from the line rising to the wake pulse
   task automatic raise(input logic [1:0] s, input logic [2:0] p, output int n);
      @(posedge clock);
      fire <= 1'h1;
      source <= s;
      pin <= p;
      @(posedge clock);
      fire <= 1'h0;
      n = 0;
      while (wake === 4'h0 && n < 2000) begin
         @(posedge clock);
         #1;
         n++;
      end
   endtask : raise

   task automatic t_regs;
      rd("select reset", OFS_SELECT, 32'h0000_0000);
      rd("settle reset", OFS_SETTLE, {29'h0000_0000, SETTLE_RESET});
      rd("periph reset", OFS_PERIPH, {13'h0000, PERIPH_RESET});
      rd("status normal", OFS_STATUS, 32'h0000_0000);
      rd("trigger normal", OFS_TRIGGER, 32'h0000_0000);
      rd("unmapped", 8'h14, 32'h0000_0000);
   endtask : t_regs

   task automatic t_idle_pins;
      int n;
      wr(OFS_PERIPH, 32'h0000_0000);
      for (int p = 0; p < EXT_PIN_COUNT; p++) begin
         enter(1'h0);
         rd("status idle", OFS_STATUS, 32'h0000_0011);
         raise(2'h1, p[2:0], n);
         chk("idle wake delay", 1, n);
         chk("wake di", 4'h2, wake);
         chk("clocks back", 12'hfff, clk_en);
         chk("port release", 1'h0, port_hold);
      end
      wr(OFS_PERIPH, 32'h0000_1000);
      enter(1'h0);
      raise(2'h1, 3'h0, n);
      chk("masked pin", 1'h1, port_hold);
      raise(2'h0, 3'h0, n);
      chk("nmi wake di", 4'hd, wake);
   endtask : t_idle_pins

   task automatic t_idle_gating;
      int n;
      wr(OFS_PERIPH, 32'h0000_0159);
      @(posedge clock);
      dac_busy <= 1'h1;
      enter(1'h0);
      chk("rtc baud", 1'h1, clk_en.rtc);
      chk("adc baud", 1'h1, clk_en.adc);
      chk("csi ext", 5'h15, clk_en.csi);
      chk("dac finishing", 1'h1, clk_en.dac);
      chk("dac hold early", 1'h0, dac_hold);
      dac_busy <= 1'h0;
      repeat (3) @(posedge clock);
      #1;
      chk("dac stopped", 1'h0, clk_en.dac);
      chk("dac held", 1'h1, dac_hold);
      raise(2'h2, 3'h0, n);
      wr(OFS_PERIPH, 32'h0000_00a6);
      enter(1'h0);
      chk("rtc sub", 1'h1, clk_en.rtc);
      chk("adc other", 1'h0, clk_en.adc);
      chk("csi ext b", 5'h0a, clk_en.csi);
      raise(2'h2, 3'h0, n);
   endtask : t_idle_gating

   task automatic t_stop;
      int n;
      for (int s = 0; s < 2; s++) begin
         wr(OFS_SETTLE, s);
         enter(1'h1);
         chk("sub osc", 1'h1, clk_en.sub_osc);
         chk("stop rtc sub", 1'h1, clk_en.rtc);
         chk("stop csi", 5'h0a, clk_en.csi);
         chk("stop adc", 1'h0, clk_en.adc);
         wr(OFS_SELECT, 32'h0000_0000);
         rd("select kept", OFS_SELECT, 32'h0000_0001);
         raise(2'h0, 3'h0, n);
         // One edge leaves stop, then the programmed settle count runs down
         chk("settle wait", 1 + (BASE << s), n);
         chk("nmi wake", 4'hd, wake);
         chk("clocks back", 12'hfff, clk_en);
      end
   endtask : t_stop

   task automatic t_priority;
      logic [2:0] pr[4] = '{3'h5, 3'h1, 3'h1, 3'h7};
      logic en[4] = '{1'h1, 1'h1, 1'h0, 1'h1};
      logic sv[4] = '{1'h1, 1'h1, 1'h1, 1'h0};
      logic [3:0] exp[4] = '{4'h2, 4'h5, 4'h2, 4'h5};
      int n;
      @(posedge clock);
      serv_priority <= 3'h3;
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         req_priority <= pr[i];
         ints_enabled_state <= en[i];
         serv_active <= sv[i];
         enter(1'h0);
         raise(2'h2, 3'h0, n);
         chk("wake decision", exp[i], wake);
      end
   endtask : t_priority

   task automatic t_reset_pin;
      int n;
      wr(OFS_SETTLE, 32'h0000_0000);
      enter(1'h1);
      @(posedge clock);
      reset_pin <= 1'h1;
      @(posedge clock);
      reset_pin <= 1'h0;
      #1;
      chk("cpu reset stop", 1'h1, cpu_reset);
      // The read spends the first two edges of the settle wait
      rd("status settle", OFS_STATUS, 32'h0000_0063);
      n = 2;
      while (clk_en.cpu !== 1'h1 && n < 2000) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk("reset settle", RST_CYC, n);
      rd("select cleared", OFS_SELECT, 32'h0000_0000);
      enter(1'h0);
      @(posedge clock);
      reset_pin <= 1'h1;
      @(posedge clock);
      reset_pin <= 1'h0;
      #1;
      chk("cpu reset idle", 1'h1, cpu_reset);
      chk("idle left", 12'hfff, clk_en);
      rd("status after", OFS_STATUS, 32'h0000_0000);
   endtask : t_reset_pin

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         print_verdict();
      end
   end

   initial begin
      repeat (20) @(posedge clock);
      reset <= 1'h0;
      t_regs();
      t_idle_pins();
      t_idle_gating();
      t_stop();
      t_priority();
      t_reset_pin();
      print_verdict();
   end
endmodule : ispc_ctrl_bench
